/* File: core/ladder_if.sv */
// Carrier between the register block and the ladder level computation
`timescale 1ns/1ps
interface ladder_if;
    logic       range_sel;
    logic [3:0] level_code;
    logic [6:0] level96;

    // Register side drives settings, level side returns the level
    modport ctrl (output range_sel, output level_code, input level96);
    modport tap  (input range_sel, input level_code, output level96);
endinterface : ladder_if

/* File: core/ladder_level.sv */
// Computes the ladder output level in 96ths of the source span
`timescale 1ns/1ps
module ladder_level (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    // Settings in, level out
    ladder_if.tap     lk
);

    typedef struct packed {
        logic [6:0] level96;
    } lvl_state_t;

    lvl_state_t s_q;
    lvl_state_t s_d;

    // Wide range steps span/24, fine range span/4 plus span/32 steps
    function automatic logic [6:0] level_of(input logic range_sel, input logic [3:0] code);
        logic [6:0] c;
        c = {3'h0, code};
        if (range_sel) begin
            level_of = 7'(c * vref_pkg::STEP_WIDE);
        end else begin
            level_of = 7'(vref_pkg::BASE_FINE + c * vref_pkg::STEP_FINE);
        end
    endfunction : level_of

    // Next level from the current settings
    always_comb begin
        s_d         = s_q;
        s_d.level96 = level_of(lk.range_sel, lk.level_code);
    end

    // Registered so the level pin is glitch free
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign lk.level96 = s_q.level96;

    // Wide range: code times four 96ths; release edge skipped, level still held at zero
    wide_level_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $past(i_arst_n) && lk.range_sel |=> lk.level96 == 7'($past(lk.level_code) * 4))
        else $error("wide range level wrong");

    // Fine range: a quarter plus code over 32; release edge skipped as above
    fine_level_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $past(i_arst_n) && !lk.range_sel |=> lk.level96 == 7'(24 + $past(lk.level_code) * 3))
        else $error("fine range level wrong");

    // Range bounds: top of either range is below three quarters
    range_bound_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        ##1 lk.level96 <= 7'h48)
        else $error("ladder level beyond range");

endmodule : ladder_level

/* File: core/vref_ladder_ctrl.sv */
// Reference ladder control: APB register, ladder settings and pin routing
//
// Overview of operation
// - Control bit 7 powers the ladder on; zero powers it down.
// - Control bit 6 routes the ladder level onto port A pin 0.
// - Pin drive overrides pin 0 direction; software must make pin 2 input.
// - Bit 5 picks range: one gives span/24 steps, zero span/32 from quarter.
// - Bit 4 picks source: external reference pins or device supply rails.
// - Bits 3 to 0 hold the level code, one of sixteen taps.
// - Range one: level equals code over 24 times span.
// - Range zero: level equals quarter span plus code over 32 times span.
// - Reset clears power, pin drive, range and level code bits.
// - Waking from sleep leaves the control register unchanged.
// - Ladder works regardless of comparator mode settings.
// - Every control bit is readable, writable and resets to zero.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
module vref_ladder_ctrl (
    // Clock and reset
    input  wire logic        I_MCLK,
    input  wire logic        I_ARST_N,
    // APB slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    input  wire logic [3:0]  I_PSTRB,
    output logic             O_PREADY,
    output logic [31:0]      O_PRDATA,
    output logic             O_PSLVERR,
    // Port A direction bits from the port logic, 1 means input
    input  wire logic [7:0]  I_PORT_A_DIRECTION,
    // Sleep indication, the settings do not depend on it
    input  wire logic        I_SLEEP,
    // Analog ladder controls
    output logic             O_LADDER_POWER_ON,
    output logic             O_LADDER_PIN_DRIVE,
    output logic             O_LADDER_RANGE_SELECT,
    output logic             O_LADDER_SOURCE_SELECT,
    output logic [3:0]       O_LADDER_LEVEL_CODE,
    output logic [6:0]       O_LADDER_OUTPUT_LEVEL,
    // Port A pin 0 routing
    output logic             O_PORT_A_PIN0_ANALOG,
    output logic             O_PORT_A_PIN0_DIR
);

    typedef struct packed {
        vref_pkg::apb_state_t st;
        logic                 pready;
        logic                 pslverr;
        logic [31:0]          prdata;
        logic [7:0]           ctrl;
        logic                 pin0_analog;
        logic                 pin0_dir;
        logic                 pin2_warn;
    } ctrl_state_t;

    localparam ctrl_state_t STATE_RESET = '{
        st:          vref_pkg::APB_IDLE,
        pready:      1'b0,
        pslverr:     1'b0,
        prdata:      32'h0000_0000,
        ctrl:        vref_pkg::CTRL_RESET,
        pin0_analog: 1'b0,
        pin0_dir:    1'b0,
        pin2_warn:   1'b0
    };

    ctrl_state_t s_q;
    ctrl_state_t s_d;
    ladder_if    lk ();

    logic        setup_phase;
    logic        write_done;

    // Address decode, used by the error answer
    function automatic logic is_mapped(input logic [11:0] addr);
        is_mapped = (addr == vref_pkg::ADDR_CTRL) || (addr == vref_pkg::ADDR_STATUS);
    endfunction : is_mapped

    // Read data for a mapped address, zero elsewhere
    function automatic logic [31:0] read_word(input logic [11:0] addr,
                                              input ctrl_state_t s,
                                              input logic [6:0]  lvl);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (addr == vref_pkg::ADDR_CTRL) begin
            w[7:0] = s.ctrl;
        end else if (addr == vref_pkg::ADDR_STATUS) begin
            w[vref_pkg::STAT_POWERED]    = s.ctrl[vref_pkg::BIT_POWER_ON];
            w[vref_pkg::STAT_PIN_ROUTED] = s.pin0_analog;
            w[vref_pkg::STAT_PIN2_WARN]  = s.pin2_warn;
            w[vref_pkg::STAT_LEVEL_LSB +: vref_pkg::LEVEL_W] = lvl;
        end
        read_word = w;
    endfunction : read_word

    // Bus phase qualifiers
    assign setup_phase = I_PSEL && !I_PENABLE;
    assign write_done  = (s_q.st == vref_pkg::APB_ACK) && I_PSEL && I_PENABLE && I_PWRITE
                         && (I_PADDR == vref_pkg::ADDR_CTRL) && I_PSTRB[0];

    // Next state: APB answer, control register, pin routing
    always_comb begin
        s_d         = s_q;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        unique case (s_q.st)
            vref_pkg::APB_IDLE: begin
                if (setup_phase) begin
                    // Answer in the first access cycle, no wait states
                    s_d.st      = vref_pkg::APB_ACK;
                    s_d.pready  = 1'b1;
                    s_d.pslverr = !is_mapped(I_PADDR);
                    s_d.prdata  = I_PWRITE ? 32'h0000_0000 : read_word(I_PADDR, s_q, lk.level96);
                end
            end
            vref_pkg::APB_ACK: begin
                s_d.st     = vref_pkg::APB_IDLE;
                s_d.prdata = 32'h0000_0000;
                // Only a completed write changes the settings; sleep does not
                if (write_done) begin
                    s_d.ctrl = I_PWDATA[7:0];
                end
            end
        endcase
        // Pin drive forces pin 0 to analog input, overriding its direction bit
        s_d.pin0_analog = s_d.ctrl[vref_pkg::BIT_PIN_DRIVE];
        s_d.pin0_dir    = s_d.ctrl[vref_pkg::BIT_PIN_DRIVE]
                          || I_PORT_A_DIRECTION[vref_pkg::PA_PIN_OUT];
        // Software still has to make pin 2 an input; flag it when it did not
        s_d.pin2_warn   = s_d.ctrl[vref_pkg::BIT_PIN_DRIVE]
                          && !I_PORT_A_DIRECTION[vref_pkg::PA_PIN_IN];
    end

    // Single state register; reset clears every control bit
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Settings go to the level computation with no comparator gating
    assign lk.range_sel  = s_q.ctrl[vref_pkg::BIT_RANGE_SEL];
    assign lk.level_code = s_q.ctrl[vref_pkg::CODE_MSB:vref_pkg::CODE_LSB];

    ladder_level u_level (
        .i_clk    (I_MCLK),
        .i_arst_n (I_ARST_N),
        .lk       (lk.tap)
    );

    // APB answer straight from the state register
    assign O_PREADY  = s_q.pready;
    assign O_PSLVERR = s_q.pslverr;
    assign O_PRDATA  = s_q.prdata;

    // Ladder controls straight from the register bits, no extra gating
    assign O_LADDER_POWER_ON      = s_q.ctrl[vref_pkg::BIT_POWER_ON];
    assign O_LADDER_PIN_DRIVE     = s_q.ctrl[vref_pkg::BIT_PIN_DRIVE];
    assign O_LADDER_RANGE_SELECT  = s_q.ctrl[vref_pkg::BIT_RANGE_SEL];
    assign O_LADDER_SOURCE_SELECT = s_q.ctrl[vref_pkg::BIT_SOURCE_SEL];
    assign O_LADDER_LEVEL_CODE    = s_q.ctrl[vref_pkg::CODE_MSB:vref_pkg::CODE_LSB];
    assign O_LADDER_OUTPUT_LEVEL  = lk.level96;
    assign O_PORT_A_PIN0_ANALOG   = s_q.pin0_analog;
    assign O_PORT_A_PIN0_DIR      = s_q.pin0_dir;

    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_ARST_N);

    // Every setup phase seen while idle is answered in the next cycle, for one cycle only
    apb_answer_a: assert property (
        (s_q.st == vref_pkg::APB_IDLE) && setup_phase |=> O_PREADY ##1 !O_PREADY)
        else $error("APB answer timing wrong");

    // Power bit follows the written value one edge after the write
    power_follow_a: assert property (
        write_done |=> O_LADDER_POWER_ON == $past(I_PWDATA[7]))
        else $error("power bit not taken from write");

    // Pin routing tracks the pin drive bit
    pin_route_a: assert property (
        O_PORT_A_PIN0_ANALOG == O_LADDER_PIN_DRIVE)
        else $error("pin 0 routing disagrees with pin drive");

    // Pin drive forces pin 0 direction to input
    dir_override_a: assert property (
        O_LADDER_PIN_DRIVE |-> O_PORT_A_PIN0_DIR)
        else $error("pin 0 direction not overridden");

    // Range and source bits taken from the write data
    range_source_a: assert property (
        write_done |=> O_LADDER_SOURCE_SELECT == $past(I_PWDATA[4])
                       && O_LADDER_RANGE_SELECT == $past(I_PWDATA[5]))
        else $error("range or source bit not written");

    // Level code taken from the write data
    level_code_a: assert property (
        write_done |=> O_LADDER_LEVEL_CODE == $past(I_PWDATA[3:0]))
        else $error("level code not written");

    // First edge after reset release shows a cleared register
    reset_clear_a: assert property (
        $rose(I_ARST_N) |-> s_q.ctrl == 8'h00 && !O_PORT_A_PIN0_ANALOG)
        else $error("control not cleared by reset");

    // Without a completed write the settings hold, asleep or awake
    hold_settings_a: assert property (
        !write_done |=> $stable(s_q.ctrl))
        else $error("settings changed without a write");

    // Read of the control register returns its value in the answer
    read_back_a: assert property (
        (s_q.st == vref_pkg::APB_IDLE) && setup_phase && !I_PWRITE
        && I_PADDR == vref_pkg::ADDR_CTRL |=> O_PRDATA[7:0] == $past(s_q.ctrl))
        else $error("control read back wrong");

    // Unmapped address answers with an error
    unmapped_err_a: assert property (
        (s_q.st == vref_pkg::APB_IDLE) && setup_phase && !is_mapped(I_PADDR) |=> O_PSLVERR)
        else $error("unmapped access not flagged");

    // A write lands only at the edge where the answer stands
    write_lands_a: assert property (
        write_done |-> O_PREADY)
        else $error("write landed outside the answer");

    // Cleared byte strobe leaves the register alone
    strobe_refused_a: assert property (
        (s_q.st == vref_pkg::APB_ACK) && I_PSEL && I_PENABLE && I_PWRITE
        && !I_PSTRB[0] |=> $stable(s_q.ctrl))
        else $error("write without strobe changed control");

    // Status is read only, writes to it are dropped
    status_write_a: assert property (
        (s_q.st == vref_pkg::APB_ACK) && I_PSEL && I_PENABLE && I_PWRITE
        && I_PADDR == vref_pkg::ADDR_STATUS |=> $stable(s_q.ctrl))
        else $error("status write changed control");

    // Every answer follows a setup phase seen while idle
    answer_once_a: assert property (
        O_PREADY |-> $past(setup_phase) && $past(s_q.st) == vref_pkg::APB_IDLE)
        else $error("answer without setup");

    // No setup, no answer
    no_answer_a: assert property (
        (s_q.st == vref_pkg::APB_IDLE) && !setup_phase |=> !O_PREADY)
        else $error("answer without request");

    // Error only travels with the answer
    error_with_ready_a: assert property (
        O_PSLVERR |-> O_PREADY)
        else $error("error outside the answer");

    // Read data is zero outside the answer cycle
    rdata_quiet_a: assert property (
        !O_PREADY |-> O_PRDATA == 32'h0000_0000)
        else $error("read data outside the answer");

    // Upper bits of the control word read as zero
    read_upper_a: assert property (
        (s_q.st == vref_pkg::APB_IDLE) && setup_phase && !I_PWRITE
        && I_PADDR == vref_pkg::ADDR_CTRL |=> O_PRDATA[31:8] == 24'h000000)
        else $error("control upper bits not zero");

    // Status shows power and pin routing as they stood at setup
    status_bits_a: assert property (
        (s_q.st == vref_pkg::APB_IDLE) && setup_phase && !I_PWRITE
        && I_PADDR == vref_pkg::ADDR_STATUS
        |=> O_PRDATA[vref_pkg::STAT_POWERED] == $past(O_LADDER_POWER_ON)
        && O_PRDATA[vref_pkg::STAT_PIN_ROUTED] == $past(O_PORT_A_PIN0_ANALOG))
        else $error("status bits wrong");

    // Status shows the ladder level as it stood at setup
    status_level_a: assert property (
        (s_q.st == vref_pkg::APB_IDLE) && setup_phase && !I_PWRITE
        && I_PADDR == vref_pkg::ADDR_STATUS
        |=> O_PRDATA[vref_pkg::STAT_LEVEL_LSB +: vref_pkg::LEVEL_W]
        == $past(O_LADDER_OUTPUT_LEVEL))
        else $error("status level wrong");

    // Warning when pin drive is on but pin 2 is not an input
    pin2_warn_a: assert property (
        s_q.pin2_warn
        == (O_LADDER_PIN_DRIVE && !$past(I_PORT_A_DIRECTION[vref_pkg::PA_PIN_IN])))
        else $error("pin 2 warning wrong");

    // Pin 0 direction follows its bit one cycle late unless overridden
    pin0_dir_a: assert property (
        $past(I_ARST_N) |-> O_PORT_A_PIN0_DIR
        == (O_LADDER_PIN_DRIVE || $past(I_PORT_A_DIRECTION[vref_pkg::PA_PIN_OUT])))
        else $error("pin 0 direction wrong");

    // Sleep alone never disturbs the settings
    sleep_hold_a: assert property (
        I_SLEEP && !write_done |=> $stable(s_q.ctrl))
        else $error("settings changed in sleep");

    // The whole written byte reaches the register in one clock
    full_byte_a: assert property (
        write_done |=> s_q.ctrl == $past(I_PWDATA[7:0]))
        else $error("written byte not taken whole");

    // Main scenarios
    cov_power_up_c:   cover property (write_done && I_PWDATA[7] ##1 O_LADDER_POWER_ON);
    cov_pin_route_c:  cover property (write_done && I_PWDATA[6] ##1 O_PORT_A_PIN0_ANALOG);
    cov_fine_top_c:   cover property (!O_LADDER_RANGE_SELECT && O_LADDER_LEVEL_CODE == 4'hF);
    cov_sleep_hold_c: cover property (I_SLEEP && O_LADDER_POWER_ON [*4]);
    cov_wide_top_c:   cover property (O_LADDER_RANGE_SELECT && O_LADDER_LEVEL_CODE == 4'hF);

endmodule : vref_ladder_ctrl

/* File: core/vref_pkg.sv */
// Constants and types shared by the reference ladder control block
package vref_pkg;

    // APB address map, byte addresses
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_STATUS     = 12'h004;

    // Control register layout and reset value
    localparam int          CTRL_W          = 8;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam int          BIT_POWER_ON    = 7;
    localparam int          BIT_PIN_DRIVE   = 6;
    localparam int          BIT_RANGE_SEL   = 5;
    localparam int          BIT_SOURCE_SEL  = 4;
    localparam int          CODE_MSB        = 3;
    localparam int          CODE_LSB        = 0;
    localparam int          CODE_W          = 4;

    // Status register layout
    localparam int          STAT_POWERED    = 0;
    localparam int          STAT_PIN_ROUTED = 1;
    localparam int          STAT_PIN2_WARN  = 2;
    localparam int          STAT_LEVEL_LSB  = 8;

    // Ladder level as a fraction of the source span, in 96ths
    localparam int          LEVEL_W         = 7;
    localparam logic [6:0]  LEVEL_DEN       = 7'h60;
    localparam logic [6:0]  STEP_WIDE       = 7'h04;
    localparam logic [6:0]  STEP_FINE       = 7'h03;
    localparam logic [6:0]  BASE_FINE       = 7'h18;

    // Port A bits touched by the pin drive
    localparam int          PA_PIN_OUT      = 0;
    localparam int          PA_PIN_IN       = 2;

    // APB slave sequencing, one-hot
    typedef enum logic [1:0] {
        APB_IDLE = 2'b01,
        APB_ACK  = 2'b10
    } apb_state_t;

endpackage : vref_pkg

/* File: tb/tb.sv */
// Self-checking bench for the reference ladder control block
`timescale 1ns/1ps
module tb;
    // Bus, port and ladder signals
    logic        mclk;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [7:0]  dir;
    logic        sleep;
    logic        pwr;
    logic        pin;
    logic        rng;
    logic        src;
    logic [3:0]  code;
    logic [6:0]  level;
    logic        pin0_an;
    logic        pin0_dir;
    // Bench state and reference model
    integer      num_errors;
    integer      cmp_count;
    integer      seed;
    integer      model_ctrl;
    integer      i;
    logic [31:0] rd;
    logic        err;
    logic [11:0] ra;

    vref_ladder_ctrl u_dut (
        .I_MCLK(mclk), .I_ARST_N(arst_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
        .O_PREADY(pready), .O_PRDATA(prdata), .O_PSLVERR(pslverr),
        .I_PORT_A_DIRECTION(dir), .I_SLEEP(sleep), .O_LADDER_POWER_ON(pwr),
        .O_LADDER_PIN_DRIVE(pin), .O_LADDER_RANGE_SELECT(rng),
        .O_LADDER_SOURCE_SELECT(src), .O_LADDER_LEVEL_CODE(code),
        .O_LADDER_OUTPUT_LEVEL(level), .O_PORT_A_PIN0_ANALOG(pin0_an),
        .O_PORT_A_PIN0_DIR(pin0_dir)
    );

    // 250 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // Level in 96ths: span/24 steps from zero, or span/32 steps above a quarter
    function automatic integer lvl(input integer c);
        lvl = c[5] ? (c % 16) * 4 : 24 + (c % 16) * 3;
    endfunction : lvl

    // One APB transfer; port direction and sleep settle a cycle before setup
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [7:0] dv, input logic sl);
        integer n;
        @(posedge mclk);
        dir   <= dv;
        sleep <= sl;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            num_errors = num_errors + 1;
            $display("unexpected pready: expected 1, seen %b", pready);
            conclude();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (wr && a == vref_pkg::ADDR_CTRL && s[0]) model_ctrl = d[7:0];
    endtask : apb

    // Ladder outputs once the write and the level stage have landed
    task automatic chk_out;
        @(posedge mclk);
        #1;
        chk("power", model_ctrl[7], pwr);
        chk("pin drive", model_ctrl[6], pin);
        chk("pin0 analog", model_ctrl[6], pin0_an);
        chk("pin0 dir", model_ctrl[6] ? 1'b1 : dir[0], pin0_dir);
        chk("range", model_ctrl[5], rng);
        chk("source", model_ctrl[4], src);
        chk("code", model_ctrl % 16, code);
        chk("level", lvl(model_ctrl), level);
    endtask : chk_out

    // Transfer with read data, error and outputs checked against the model
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [7:0] dv, input logic sl);
        integer exp;
        logic   ctl;
        logic   sts;
        ctl = (a == vref_pkg::ADDR_CTRL);
        sts = (a == vref_pkg::ADDR_STATUS);
        apb(wr, a, d, s, dv, sl);
        exp = model_ctrl;
        if (sts) begin
            exp = lvl(model_ctrl) * 256 + (model_ctrl[6] && !dv[2]) * 4
                + model_ctrl[6] * 2 + model_ctrl[7];
        end
        chk("pslverr", !(ctl || sts), err);
        if (!wr) chk("prdata", (ctl || sts) ? exp : 0, rd);
        chk_out();
    endtask : xfer

    task automatic do_reset;
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        model_ctrl = 0;
        chk_out();
    endtask : do_reset

    // Main sequence
    initial begin
        num_errors = 0;
        cmp_count  = 0;
        seed       = 32'hd00e4775;
        model_ctrl = 0;
        arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0000_0000; pstrb = 4'h0;
        dir = 8'hFF; sleep = 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        chk_out();
        xfer(1'b0, vref_pkg::ADDR_CTRL, 32'h0, 4'hF, 8'hFF, 1'b0);
        xfer(1'b0, vref_pkg::ADDR_STATUS, 32'h0, 4'hF, 8'hFF, 1'b0);
        $display("test reset done");
        // Walking one through every control bit, upper write bits ignored
        for (i = 0; i < 8; i++) begin
            xfer(1'b1, vref_pkg::ADDR_CTRL, 32'hFFFF_FF00 | (1 << i), 4'h1, 8'h00, 1'b0);
            xfer(1'b0, vref_pkg::ADDR_CTRL, 32'h0, 4'hF, 8'h00, 1'b0);
        end
        $display("test bits done");
        // Every code in both ranges, back to back with status reads
        for (i = 0; i < 32; i++) begin
            xfer(1'b1, vref_pkg::ADDR_CTRL,
                 ($random(seed) & 32'hD0) | ((i & 16) << 1) | (i & 15), 4'hF,
                 8'($random(seed)), 1'b0);
            xfer(1'b0, vref_pkg::ADDR_STATUS, 32'h0, 4'hF, 8'($random(seed)), 1'b0);
        end
        $display("test sweep done");
        // Settings held across sleep while software only reads
        xfer(1'b1, vref_pkg::ADDR_CTRL, 32'hC7, 4'h1, 8'h00, 1'b0);
        for (i = 0; i < 4; i++) begin
            xfer(1'b0, vref_pkg::ADDR_CTRL, 32'h0, 4'hF, 8'h05, i[0]);
        end
        $display("test sleep done");
        // Random traffic: refused strobes, status writes, unmapped places
        for (i = 0; i < 80; i++) begin
            case ($unsigned($random(seed)) % 4)
                0, 1: ra = vref_pkg::ADDR_CTRL;
                2: ra = vref_pkg::ADDR_STATUS;
                default: ra = 12'h008 + 12'(($unsigned($random(seed)) % 64) * 4);
            endcase
            xfer(1'($random(seed)), ra, $random(seed), 4'($random(seed)), 8'($random(seed)),
                 1'($random(seed)));
        end
        $display("test random done");
        // Reset in mid-run clears a loaded register
        xfer(1'b1, vref_pkg::ADDR_CTRL, 32'hFF, 4'hF, 8'h00, 1'b1);
        do_reset();
        xfer(1'b0, vref_pkg::ADDR_CTRL, 32'h0, 4'hF, 8'h00, 1'b0);
        $display("test second reset done");
        conclude();
    end
endmodule : tb
